// >>> asm_host.sv
/*
  asm_host: host controller that drives a 64K x 32 asynchronous static
  memory module through its pins, one word or byte subset per request.
  assumes the module pins are wired directly; the data bus wire level is
  resolved outside from data_bus_oe_n_out. user requests are synchronous.
*/
`timescale 1ns/1ns
module asm_host #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 32
) (
  // clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                rst_n_in,
  // user request
  input  wire logic                req_valid_in,
  input  wire logic                req_write_in,
  input  wire logic [ADDR_W-1:0]   req_addr_in,
  input  wire logic [DATA_W-1:0]   req_wdata_in,
  input  wire logic [3:0]          req_bytes_in,
  output logic                     req_ready_out,
  output logic                     rsp_valid_out,
  output logic [DATA_W-1:0]        rsp_rdata_out,
  output logic [1:0]               density_id_out,
  // module pins
  output logic [ADDR_W-1:0]        word_address_out,
  output logic                     write_n_out,
  output logic                     output_en_n_out,
  output logic                     byte_select0_n_out,
  output logic                     byte_select1_n_out,
  output logic                     byte_select2_n_out,
  output logic                     byte_select3_n_out,
  output logic [DATA_W-1:0]        data_bus_out,
  output logic                     data_bus_oe_n_out,
  input  wire logic [DATA_W-1:0]   data_bus_in,
  input  wire logic                density_id_bit0_in,
  input  wire logic                density_id_bit1_in
);

  // ************************************************************
  // parameter checks
  // ************************************************************
  // the lane selects are fixed at four, so the data width cannot move
  if (ADDR_W != 16 || DATA_W != 32)
  begin : g_bad_width
    $error("asm_host serves only 16 address and 32 data lines");
  end
  // the longest wait, the start-up recovery, must fit the down counter
  if (asm_pkg::RC_CYC >= (1 << asm_pkg::CNT_W))
  begin : g_bad_count
    $error("asm_host recovery count exceeds its counter");
  end

  // ************************************************************
  // state
  // ************************************************************
  asm_pkg::asm_state_t          st_r, st_nxt;
  logic [asm_pkg::CNT_W-1:0]    cnt_r, cnt_nxt;
  logic [ADDR_W-1:0]            addr_r, addr_nxt;
  logic [DATA_W-1:0]            wdat_r, wdat_nxt;
  logic [DATA_W-1:0]            rdat_r, rdat_nxt;
  logic [3:0]                   sel_n_r, sel_n_nxt;
  logic                         we_n_r, we_n_nxt;
  logic                         oe_n_r, oe_n_nxt;
  logic                         drv_n_r, drv_n_nxt;
  logic                         rdy_r, rdy_nxt;
  logic                         rsp_r, rsp_nxt;
  logic [1:0]                   did_r, did_nxt;

  function automatic logic [asm_pkg::CNT_W-1:0] cyc(input int n);
    cyc = asm_pkg::CNT_W'(n - 1);
  endfunction : cyc

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    addr_nxt  = addr_r;
    wdat_nxt  = wdat_r;
    rdat_nxt  = rdat_r;
    sel_n_nxt = sel_n_r;
    we_n_nxt  = we_n_r;
    oe_n_nxt  = oe_n_r;
    drv_n_nxt = drv_n_r;
    rdy_nxt   = 1'b0;
    rsp_nxt   = 1'b0;
    did_nxt   = {density_id_bit1_in, density_id_bit0_in};
    if (cnt_r != '0)
      cnt_nxt = cnt_r - 1'b1;
    unique case (st_r)
      asm_pkg::ASM_IDLE:
      begin
        rdy_nxt = 1'b1;
        if (req_valid_in && rdy_r && req_bytes_in != 4'h0)
        begin
          rdy_nxt  = 1'b0;
          // address and selects move together so address is never late
          addr_nxt = req_addr_in;
          sel_n_nxt = ~req_bytes_in;
          if (req_write_in)
          begin
            wdat_nxt  = req_wdata_in;
            we_n_nxt  = 1'b0;
            oe_n_nxt  = 1'b1;
            drv_n_nxt = 1'b0;
            cnt_nxt   = cyc(asm_pkg::WR_CYC);
            st_nxt    = asm_pkg::ASM_WR_PULSE;
          end
          else
          begin
            oe_n_nxt = 1'b0;
            cnt_nxt  = cyc(asm_pkg::RD_CYC);
            st_nxt   = asm_pkg::ASM_RD_ACC;
          end
        end
      end
      asm_pkg::ASM_RD_ACC:
        if (cnt_r == '0)
        begin
          // sample while address still stands, within output hold
          rdat_nxt  = data_bus_in;
          rsp_nxt   = 1'b1;
          sel_n_nxt = asm_pkg::SEL_IDLE;
          oe_n_nxt  = 1'b1;
          cnt_nxt   = cyc(asm_pkg::HZ_CYC);
          st_nxt    = asm_pkg::ASM_RD_REL;
        end
      asm_pkg::ASM_RD_REL:
        if (cnt_r == '0)
          st_nxt = asm_pkg::ASM_IDLE;
      asm_pkg::ASM_WR_PULSE:
        if (cnt_r == '0)
        begin
          // write ends on both edges at once; data stays driven
          we_n_nxt  = 1'b1;
          sel_n_nxt = asm_pkg::SEL_IDLE;
          cnt_nxt   = cyc(asm_pkg::AH_CYC + asm_pkg::LZ_CYC);
          st_nxt    = asm_pkg::ASM_WR_HOLD;
        end
      asm_pkg::ASM_WR_HOLD:
        if (cnt_r == '0)
        begin
          drv_n_nxt = 1'b1;
          st_nxt    = asm_pkg::ASM_IDLE;
        end
      asm_pkg::ASM_RECOVER:
        if (cnt_r == '0)
          st_nxt = asm_pkg::ASM_IDLE;
      // two codes of the state word are unused; fall back to rest
      default:
        st_nxt = asm_pkg::ASM_IDLE;
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r    <= asm_pkg::ASM_RECOVER;
      cnt_r   <= asm_pkg::CNT_W'(asm_pkg::RC_CYC);
      addr_r  <= '0;
      wdat_r  <= '0;
      rdat_r  <= '0;
      sel_n_r <= asm_pkg::SEL_IDLE;
      we_n_r  <= 1'b1;
      oe_n_r  <= 1'b1;
      drv_n_r <= 1'b1;
      rdy_r   <= 1'b0;
      rsp_r   <= 1'b0;
      did_r   <= 2'h0;
    end
    else
    begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      addr_r  <= addr_nxt;
      wdat_r  <= wdat_nxt;
      rdat_r  <= rdat_nxt;
      sel_n_r <= sel_n_nxt;
      we_n_r  <= we_n_nxt;
      oe_n_r  <= oe_n_nxt;
      drv_n_r <= drv_n_nxt;
      rdy_r   <= rdy_nxt;
      rsp_r   <= rsp_nxt;
      did_r   <= did_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign req_ready_out      = rdy_r;
  assign rsp_valid_out      = rsp_r;
  assign rsp_rdata_out      = rdat_r;
  assign density_id_out     = did_r;
  assign word_address_out   = addr_r;
  assign write_n_out        = we_n_r;
  assign output_en_n_out    = oe_n_r;
  assign byte_select0_n_out = sel_n_r[0];
  assign byte_select1_n_out = sel_n_r[1];
  assign byte_select2_n_out = sel_n_r[2];
  assign byte_select3_n_out = sel_n_r[3];
  assign data_bus_out       = wdat_r;
  assign data_bus_oe_n_out  = drv_n_r;

endmodule : asm_host

// >>> asm_pkg.sv
/*
  asm_pkg: constants for the host-side controller of a 64K x 32
  asynchronous static memory module.
  assumes a 125 MHz core clock (8 ns period); figures are for the
  slowest speed grade so one build serves every module grade.
*/
package asm_pkg;

  localparam int CLK_PERIOD_NS = 8;

  // timing figures in ns, slowest grade
  localparam int T_RC_NS   = 35;  // read cycle
  localparam int T_AA_NS   = 35;  // address access
  localparam int T_HZ_NS   = 15;  // bus release after deselect/write
  localparam int T_AW_NS   = 20;  // address valid to end of write
  localparam int T_WP_NS   = 20;  // write pulse width
  localparam int T_DS_NS   = 15;  // data setup to end of write
  localparam int T_AH_NS   = 1;   // address hold after write
  localparam int T_LZWE_NS = 5;   // write disable to output low-z

  // least times round up to whole cycles
  localparam int RD_CYC  = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CYC  = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HZ_CYC  = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC  = (T_AW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AH_CYC  = (T_AH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LZ_CYC  = (T_LZWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 4;

  // values after reset
  localparam logic [3:0] SEL_IDLE = 4'hF;

  typedef enum logic [2:0] {
    ASM_IDLE,
    ASM_RD_ACC,
    ASM_RD_REL,
    ASM_WR_PULSE,
    ASM_WR_HOLD,
    ASM_RECOVER
  } asm_state_t;

endpackage : asm_pkg

// >>> asm_sram_model.sv
/*
  asm_sram_model: behavioural 64K x 32 static memory module.
  assumes bus_out is the resolved level of the shared data wire.
*/
`timescale 1ns/1ns
module asm_sram_model (
  input  wire logic [15:0] addr_in,
  input  wire logic        write_n_in,
  input  wire logic        output_en_n_in,
  input  wire logic [3:0]  sel_n_in,
  input  wire logic [31:0] host_d_in,
  input  wire logic        host_oe_n_in,
  output logic      [31:0] bus_out,
  output logic             density0_out,
  output logic             density1_out
);
  logic [31:0] mem [0:65535];
  logic [31:0] q;
  // late data: a too-early sample sees the old or inverted word
  assign #20 q = mem[addr_in];
  assign density0_out = 1'b0;
  assign density1_out = 1'b1;
  // a floating lane shows the inverse, never a plausible word
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      bus_out[8*i+:8] = !host_oe_n_in ? host_d_in[8*i+:8] :
        (write_n_in && !output_en_n_in && !sel_n_in[i]) ?
        q[8*i+:8] : ~q[8*i+:8];
  end
  // a lane stores at the end of its write, when address and data have
  // settled; pins that move in one step at the start never race a store
  logic [3:0] wr_on = 4'h0;
  always @(write_n_in, sel_n_in)
    for (int i = 0; i < 4; i++)
    begin
      if (wr_on[i] && (write_n_in || sel_n_in[i]))
        mem[addr_in][8*i+:8] = bus_out[8*i+:8];
      wr_on[i] = !write_n_in && !sel_n_in[i];
    end
endmodule : asm_sram_model

// >>> asm_host_chk.sv
/*
  asm_host_chk: pin sequencing checks on the host controller.
  assumes it is bound to each asm_host instance.
*/
`timescale 1ns/1ns
module asm_host_chk #(
  parameter int ADDR_W = 16
) (
  input wire logic              core_clk_in,
  input wire logic              rst_n_in,
  input wire logic              req_valid_in,
  input wire logic              req_ready_out,
  input wire logic [3:0]        req_bytes_in,
  input wire logic              rsp_valid_out,
  input wire logic [ADDR_W-1:0] word_address_out,
  input wire logic              write_n_out,
  input wire logic              output_en_n_out,
  input wire logic              byte_select0_n_out,
  input wire logic              byte_select1_n_out,
  input wire logic              byte_select2_n_out,
  input wire logic              byte_select3_n_out,
  input wire logic              data_bus_oe_n_out
);
  logic [3:0] sel;
  assign sel = {byte_select3_n_out, byte_select2_n_out,
                byte_select1_n_out, byte_select0_n_out};
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_wr;
    !write_n_out |-> sel != 4'hF && !data_bus_oe_n_out;
  endproperty
  a_wr: assert property (p_wr) else $error("write pins");
  property p_rd;
    !output_en_n_out |-> write_n_out && data_bus_oe_n_out;
  endproperty
  a_rd: assert property (p_rd) else $error("read pins");
  property p_sel; req_valid_in && req_ready_out && req_bytes_in != 4'h0
    |=> sel == ~$past(req_bytes_in); endproperty
  a_sel: assert property (p_sel) else $error("lanes");
  property p_acc; rsp_valid_out |-> !$past(output_en_n_out)
    && !$past(output_en_n_out, 5); endproperty
  a_acc: assert property (p_acc) else $error("early sample");
  property p_wp; $fell(write_n_out) |-> (!write_n_out)[*3] ##1 write_n_out;
  endproperty
  a_wp: assert property (p_wp) else $error("pulse");
  property p_aw; $fell(write_n_out) |=> $stable(word_address_out)[*3];
  endproperty
  a_aw: assert property (p_aw) else $error("addr setup");
  property p_ah; $rose(write_n_out) |=> $stable(word_address_out); endproperty
  a_ah: assert property (p_ah) else $error("addr hold");
  property p_hz; $rose(output_en_n_out) |-> data_bus_oe_n_out[*3]; endproperty
  a_hz: assert property (p_hz) else $error("bus clash");
endmodule : asm_host_chk
bind asm_host asm_host_chk #(.ADDR_W(ADDR_W)) chk_u (.*);

// >>> asm_tb.sv
/*
  testbench: asm_host against the memory model; data, lanes, refusals.
  assumes the design and model files are compiled first.
*/
`timescale 1ns/1ns
module testbench;
  logic        core_clk_in = 1'b0, rst_n_in = 1'b0;
  logic        req_valid_in = 1'b0, req_write_in = 1'b0;
  logic [15:0] req_addr_in = 16'h0000, word_address_out;
  logic [31:0] req_wdata_in = 32'h0, rsp_rdata_out, data_bus_out, data_bus_in;
  logic [3:0]  req_bytes_in = 4'h0;
  logic [1:0]  density_id_out;
  logic        req_ready_out, rsp_valid_out, write_n_out, output_en_n_out;
  logic        byte_select0_n_out, byte_select1_n_out;
  logic        byte_select2_n_out, byte_select3_n_out;
  logic        data_bus_oe_n_out, density_id_bit0_in, density_id_bit1_in;
  int          failures = 0, total_checks = 0, cyc = 0;
  asm_host dut_u (.*);
  asm_sram_model mdl_u (.addr_in(word_address_out), .write_n_in(write_n_out),
    .output_en_n_in(output_en_n_out), .sel_n_in({byte_select3_n_out,
    byte_select2_n_out, byte_select1_n_out, byte_select0_n_out}),
    .host_d_in(data_bus_out), .host_oe_n_in(data_bus_oe_n_out),
    .bus_out(data_bus_in), .density0_out(density_id_bit0_in),
    .density1_out(density_id_bit1_in));
  initial
  begin
    forever #4 core_clk_in = ~core_clk_in;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // tests take under two hundred cycles
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic req(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    @(negedge core_clk_in);
    for (int n = 0; req_ready_out !== 1'b1 && n < 40; n++)
      @(negedge core_clk_in);
    req_valid_in = 1'b1;
    req_write_in = w;
    req_addr_in = a;
    req_wdata_in = d;
    req_bytes_in = b;
    @(negedge core_clk_in);
    req_valid_in = 1'b0;
  endtask : req
  task automatic rd(input logic [15:0] a, input logic [3:0] b,
                    input logic [31:0] e);
    logic [31:0] m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    req(1'b0, a, 32'h0, b);
    for (int n = 0; rsp_valid_out !== 1'b1 && n < 20; n++)
      @(negedge core_clk_in);
    chk(rsp_rdata_out & m, e & m);
  endtask : rd
  task automatic t_word;
    req(1'b1, 16'hFFFF, 32'hA5C30F96, 4'hF);
    req(1'b1, 16'h0000, 32'h5A3CF069, 4'hF);
    rd(16'hFFFF, 4'hF, 32'hA5C30F96);
    rd(16'h0000, 4'hF, 32'h5A3CF069);
  endtask : t_word
  task automatic t_bytes;
    logic [31:0] e;
    e = 32'h0;
    req(1'b1, 16'h1234, 32'h0, 4'hF);
    for (int i = 0; i < 4; i++)
    begin
      req(1'b1, 16'h1234, {4{8'hC0 + 8'(i)}}, 4'(1 << i));
      e[8*i+:8] = 8'hC0 + 8'(i);
      rd(16'h1234, 4'hF, e);
    end
    rd(16'h1234, 4'h4, e);
  endtask : t_bytes
  task automatic t_ignore;
    req(1'b1, 16'h1234, 32'hFFFFFFFF, 4'h0);
    chk({31'h0, req_ready_out}, 32'h1);
    rd(16'h1234, 4'hF, 32'hC3C2C1C0);
    chk({30'h0, density_id_out}, 32'h2);
  endtask : t_ignore
  initial
  begin
    repeat (8) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    chk({28'h0, byte_select3_n_out, byte_select2_n_out, byte_select1_n_out,
         byte_select0_n_out}, 32'hF);
    // the start-up wait keeps the host busy for a whole read cycle
    repeat (4) @(negedge core_clk_in);
    chk({31'h0, req_ready_out}, 32'h0);
    t_word();
    t_bytes();
    t_ignore();
    final_report();
  end
endmodule : testbench
